// File: rtl/dbp_parity.sv
// parity tree: reports whether ones count plus bias is even
`timescale 1ns/100ps
`default_nettype none
module dbp_parity #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] data,
    input  wire logic         odd_in,
    output var  logic         sum_even
);
    logic [W:0] chain; // running xor, one tap per bit

    assign chain[0] = odd_in;

    // one xor stage per data bit, like a cascade of small checkers
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign chain[i+1] = chain[i] ^ data[i];
        end
    endgenerate

    // odd bias plus an odd data count gives an even total
    assign sum_even = ~chain[W];
endmodule
`default_nettype wire

// File: rtl/dbp_pkg.sv
// shared constants and carrier types for the drive-bus parity block
package dbp_pkg;

    // register byte offsets on the apb slave
    localparam logic [7:0] DBP_CS1_OFF    = 8'h00;
    localparam logic [7:0] DBP_CS2_OFF    = 8'h04;
    localparam logic [7:0] DBP_ISTAT_OFF  = 8'h08;
    localparam logic [7:0] DBP_ICLR_OFF   = 8'h0c;
    localparam logic [7:0] DBP_IEN_OFF    = 8'h10;

    // field positions
    localparam int DBP_CS1_SC_BIT   = 15; // special condition / transfer err
    localparam int DBP_CS1_CPE_BIT  = 13; // control parity error
    localparam int DBP_CS2_DPE_BIT  = 8;  // data parity error
    localparam int DBP_CS2_PAT_BIT  = 4;  // parity test select
    localparam int DBP_IRQ_SYNC_BIT = 0;  // sync parity error event
    localparam int DBP_IRQ_CTRL_BIT = 1;  // control parity error event

    // widths
    localparam int DBP_SYNC_W = 18;
    localparam int DBP_CTRL_W = 16;
    localparam int DBP_REGISTER_SELECT_W = 5;
    localparam int DBP_UNIT_W = 3;
    localparam int DBP_IRQ_W  = 2;

    // values after reset
    localparam logic [DBP_IRQ_W-1:0] DBP_IEN_RST = 2'h0;
    localparam logic                 DBP_PAT_RST = 1'b0;

    // pins arriving from the drive side and host side, sampled together
    typedef struct packed {
        logic                  host_data_strobe;
        logic                  write_op;
        logic                  remote_read_gate;
        logic                  attn_summary_select;
        logic                  error_clear;
        logic                  sync_data_gate;
        logic                  device_select;
        logic                  host_write_cycle;
        logic [DBP_SYNC_W-1:0] output_buffer;
        logic                  buffer_parity_bit;
        logic [DBP_CTRL_W-1:0] ctrl_line_in;
        logic                  ctrl_parity_in;
        logic [DBP_CTRL_W-1:0] host_write_data;
        logic [DBP_REGISTER_SELECT_W-1:0] register_select_in;
        logic [DBP_UNIT_W-1:0] unit_select_in;
    } dbp_pins_t;

    localparam int DBP_PINS_W = $bits(dbp_pins_t);

endpackage

// File: rtl/dbp_sync.sv
// two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module dbp_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] async_in,
    output var  logic [W-1:0] sync_out
);
    logic [W-1:0] meta_r; // first stage, read only by second stage

    // both stages reset to zero; all bits move together each edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r   <= '0;
            sync_out <= '0;
        end else begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: rtl/dbp_top.sv
// drive-bus parity control with apb register access
`timescale 1ns/100ps
`default_nettype none
module dbp_top
    import dbp_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output var  logic [31:0]           prdata,
    output var  logic                  pready,
    output var  logic                  pslverr,
    input  wire logic                  host_data_strobe,
    input  wire logic                  write_op,
    input  wire logic                  remote_read_gate,
    input  wire logic                  attn_summary_select,
    input  wire logic                  error_clear,
    input  wire logic                  sync_data_gate,
    input  wire logic                  device_select,
    input  wire logic                  host_write_cycle,
    input  wire logic [DBP_SYNC_W-1:0] output_buffer,
    input  wire logic                  buffer_parity_bit,
    input  wire logic [DBP_CTRL_W-1:0] ctrl_line_in,
    input  wire logic                  ctrl_parity_in,
    input  wire logic [DBP_CTRL_W-1:0] host_write_data,
    input  wire logic [DBP_REGISTER_SELECT_W-1:0] register_select_in,
    input  wire logic [DBP_UNIT_W-1:0] unit_select_in,
    output var  logic [DBP_SYNC_W-1:0] sync_data_out,
    output var  logic                  sync_data_oe_n,
    output var  logic                  sync_parity_out,
    output var  logic                  sync_parity_oe_n,
    output var  logic [DBP_CTRL_W-1:0] ctrl_line_out,
    output var  logic                  ctrl_line_oe_n,
    output var  logic                  ctrl_parity_out,
    output var  logic [DBP_REGISTER_SELECT_W-1:0] register_select,
    output var  logic [DBP_UNIT_W-1:0] unit_select,
    output var  logic                  select_oe_n,
    output var  logic                  sync_err_led,
    output var  logic                  ctrl_err_led,
    output var  logic                  irq
);

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------
    dbp_pins_t pins_async;  // raw pins gathered in one carrier
    dbp_pins_t pins;        // same pins after two flops

    assign pins_async.host_data_strobe    = host_data_strobe;
    assign pins_async.write_op            = write_op;
    assign pins_async.remote_read_gate    = remote_read_gate;
    assign pins_async.attn_summary_select = attn_summary_select;
    assign pins_async.error_clear         = error_clear;
    assign pins_async.sync_data_gate      = sync_data_gate;
    assign pins_async.device_select       = device_select;
    assign pins_async.host_write_cycle    = host_write_cycle;
    assign pins_async.output_buffer       = output_buffer;
    assign pins_async.buffer_parity_bit   = buffer_parity_bit;
    assign pins_async.ctrl_line_in        = ctrl_line_in;
    assign pins_async.ctrl_parity_in      = ctrl_parity_in;
    assign pins_async.host_write_data     = host_write_data;
    assign pins_async.register_select_in  = register_select_in;
    assign pins_async.unit_select_in      = unit_select_in;

    // data and strobes share one synchroniser so they stay aligned;
    // the far side must hold data steady around each strobe edge
    dbp_sync #(.W(DBP_PINS_W)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (pins_async),
        .sync_out (pins)
    );

    // ------------------------------------------------------------
    // trailing edge detection on the two event strobes
    // ------------------------------------------------------------
    logic strobe_d_r;  // previous synced data strobe
    logic rgate_d_r;   // previous synced read gate
    logic strobe_fall; // one-cycle pulse at strobe trailing edge
    logic rgate_fall;  // one-cycle pulse at read gate trailing edge

    // history flops look at the second sync stage only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_d_r <= 1'b0;
            rgate_d_r  <= 1'b0;
        end else begin
            strobe_d_r <= pins.host_data_strobe;
            rgate_d_r  <= pins.remote_read_gate;
        end
    end

    assign strobe_fall = strobe_d_r & ~pins.host_data_strobe;
    assign rgate_fall  = rgate_d_r & ~pins.remote_read_gate;

    // ------------------------------------------------------------
    // parity trees
    // ------------------------------------------------------------
    logic                  pat_r;        // parity test select
    logic [DBP_SYNC_W-1:0] sync_word;    // data bits seen by the tree
    logic                  sync_par_in;  // parity bit seen by the tree
    logic                  sync_even;    // sync tree result
    logic                  ctrl_even;    // control check tree result
    logic                  wr_even;      // control generate tree result

    // during writes the buffer parity bit is forced low and padded
    // words look like all zeros, so one tree serves both directions
    always_comb begin
        if (pins.write_op) begin
            sync_par_in = 1'b0;
            sync_word   = pins.sync_data_gate ?
                          pins.output_buffer : '0;
        end else begin
            sync_par_in = pins.buffer_parity_bit;
            sync_word   = pins.output_buffer;
        end
    end

    // odd bias drives every tree; test mode is applied after it, except on the control check tree
    dbp_parity #(.W(DBP_SYNC_W + 1)) u_sync_par (
        .data     ({sync_par_in, sync_word}),
        .odd_in   (1'b1),
        .sum_even (sync_even)
    );

    dbp_parity #(.W(DBP_CTRL_W + 1)) u_ctrl_chk (
        .data     ({pins.ctrl_parity_in, pins.ctrl_line_in}),
        .odd_in   (1'b1),
        .sum_even (ctrl_even)
    );

    dbp_parity #(.W(DBP_CTRL_W)) u_ctrl_gen (
        .data     (pins.host_write_data),
        .odd_in   (1'b1),
        .sum_even (wr_even)
    );

    // ------------------------------------------------------------
    // error checks
    // ------------------------------------------------------------
    logic sync_bad;  // sync word fails the selected parity
    logic ctrl_bad;  // control word fails odd parity

    // a good odd word makes the odd-biased sum even; in test mode
    // the drive sends even parity, so the sense flips
    assign sync_bad = ~(sync_even ^ pat_r);
    assign ctrl_bad = ~ctrl_even;

    // ------------------------------------------------------------
    // synchronous parity error flag
    // ------------------------------------------------------------
    logic sync_parity_error_flag_r; // sync_parity_error_flag
    logic sync_set;  // sampling event that sets the flag

    // clocked only on reads, never while write_op is high, and only while clear
    assign sync_set = strobe_fall & ~pins.write_op
                    & ~sync_parity_error_flag_r & sync_bad;

    // the error clear pin acts like a direct clear, so it wins
    // over a set in the same cycle, as the flop itself would
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_parity_error_flag_r <= 1'b0;
        end else if (pins.error_clear) begin
            sync_parity_error_flag_r <= 1'b0;
        end else if (sync_set) begin
            sync_parity_error_flag_r <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // control parity error flag
    // ------------------------------------------------------------
    logic ctrl_pe_r; // ctrl_parity_error_flag
    logic ctrl_set;  // sampling event that sets the flag

    // attention summary reads carry one bit per drive, so parity
    // over the whole word means nothing there
    assign ctrl_set = rgate_fall & ctrl_bad
                    & ~pins.attn_summary_select;

    // flag feeds itself back, so it holds until cleared
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_pe_r <= 1'b0;
        end else if (pins.error_clear) begin
            ctrl_pe_r <= 1'b0;
        end else begin
            ctrl_pe_r <= ctrl_pe_r | ctrl_set;
        end
    end

    // ------------------------------------------------------------
    // drive bus outputs
    // ------------------------------------------------------------
    // every bus output is a flop so the cable sees no glitches;
    // cost is one extra cycle after the synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_data_out    <= '0;
            sync_data_oe_n   <= 1'b1;
            sync_parity_out  <= 1'b0;
            sync_parity_oe_n <= 1'b1;
        end else begin
            sync_data_out    <= pins.output_buffer;
            sync_data_oe_n   <= ~pins.sync_data_gate;
            // padded words get the parity bit only, keeping odd
            sync_parity_out  <= ~sync_even ^ pat_r;
            sync_parity_oe_n <= ~pins.write_op;
        end
    end

    // control lines and selects for remote register access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_line_out   <= '0;
            ctrl_line_oe_n  <= 1'b1;
            ctrl_parity_out <= 1'b0;
            register_select <= '0;
            unit_select     <= '0;
            select_oe_n     <= 1'b1;
        end else begin
            ctrl_line_out   <= pins.host_write_data;
            ctrl_line_oe_n  <= ~(pins.device_select &
                                 pins.host_write_cycle);
            // even data count needs the bit set for odd parity
            ctrl_parity_out <= ~wr_even ^ pat_r;
            register_select <= pins.register_select_in;
            unit_select     <= pins.unit_select_in;
            select_oe_n     <= ~pins.device_select;
        end
    end

    // separate lamps for the two paths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_err_led <= 1'b0;
            ctrl_err_led <= 1'b0;
        end else begin
            sync_err_led <= sync_parity_error_flag_r;
            ctrl_err_led <= ctrl_pe_r;
        end
    end

    // ------------------------------------------------------------
    // status views
    // ------------------------------------------------------------
    logic [31:0] cs1_view; // first control/status word
    logic [31:0] cs2_view; // second control/status word

    // bit 15 merges both errors, as transfer and special condition
    always_comb begin
        cs1_view = '0;
        cs1_view[DBP_CS1_SC_BIT]  = sync_parity_error_flag_r | ctrl_pe_r;
        cs1_view[DBP_CS1_CPE_BIT] = ctrl_pe_r;
        cs2_view = '0;
        cs2_view[DBP_CS2_DPE_BIT] = sync_parity_error_flag_r;
        cs2_view[DBP_CS2_PAT_BIT] = pat_r;
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic                 setup_ph;  // first cycle of a transfer
    logic                 wr_take;   // write commits this edge
    logic                 addr_ok;   // address hits a register
    logic [DBP_IRQ_W-1:0] istat_r;   // sticky event bits
    logic [DBP_IRQ_W-1:0] ien_r;     // event enables
    logic [31:0]          rd_mux;    // read data for current address

    assign setup_ph = psel & ~penable;
    assign wr_take  = psel & penable & pready & pwrite & ~pslverr;

    // decode plus read selection; clear register reads as zero
    always_comb begin
        addr_ok = 1'b1;
        rd_mux  = '0;
        case (paddr)
            DBP_CS1_OFF:   rd_mux = cs1_view;
            DBP_CS2_OFF:   rd_mux = cs2_view;
            DBP_ISTAT_OFF: rd_mux = {30'h0, istat_r};
            DBP_ICLR_OFF:  rd_mux = '0;
            DBP_IEN_OFF:   rd_mux = {30'h0, ien_r};
            default:       addr_ok = 1'b0;
        endcase
    end

    // one wait-free access: answer is registered in setup so that
    // pready, prdata and pslverr all come straight from flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~addr_ok;
            if (setup_ph && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    // software owns only the parity test bit of the second word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pat_r <= DBP_PAT_RST;
        end else if (wr_take && paddr == DBP_CS2_OFF) begin
            pat_r <= pwdata[DBP_CS2_PAT_BIT];
        end
    end

    // interrupt enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_r <= DBP_IEN_RST;
        end else if (wr_take && paddr == DBP_IEN_OFF) begin
            ien_r <= pwdata[DBP_IRQ_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // interrupt status and line
    // ------------------------------------------------------------
    logic [DBP_IRQ_W-1:0] ev_set; // events this cycle
    logic [DBP_IRQ_W-1:0] ev_clr; // write-one-to-clear mask

    assign ev_set[DBP_IRQ_SYNC_BIT] = sync_set;
    assign ev_set[DBP_IRQ_CTRL_BIT] = ctrl_set & ~ctrl_pe_r;
    assign ev_clr = (wr_take && paddr == DBP_ICLR_OFF) ?
                    pwdata[DBP_IRQ_W-1:0] : '0;

    // a new event in the clearing cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            istat_r <= '0;
        end else begin
            istat_r <= (istat_r & ~ev_clr) | ev_set;
        end
    end

    // level output, one cycle behind the status bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(istat_r & ien_r);
        end
    end

endmodule
`default_nettype wire

// File: verif/dbp_asserts.sv
// concurrent checks on the drive-bus parity block ports
`timescale 1ns/100ps
`default_nettype none
module dbp_asserts
    import dbp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic write_op,
    input wire logic sync_data_gate,
    input wire logic device_select,
    input wire logic host_write_cycle,
    input wire logic error_clear,
    input wire logic sync_data_oe_n,
    input wire logic sync_parity_oe_n,
    input wire logic ctrl_line_oe_n,
    input wire logic select_oe_n,
    input wire logic sync_err_led,
    input wire logic ctrl_err_led,
    input wire logic irq
);
    logic [2:0] up_r; // edges since reset, saturates at four

    // pin history before the synchronisers fill is meaningless, so wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_r <= 3'h0;
        end else if (up_r != 3'h4) begin
            up_r <= up_r + 3'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_spoe; up_r == 3'h4 |-> sync_parity_oe_n == !$past(write_op, 3); endproperty
    a_spoe: assert property (p_spoe) else $error("sync parity enable");
    property p_sdoe; up_r == 3'h4 |-> sync_data_oe_n == !$past(sync_data_gate, 3); endproperty
    a_sdoe: assert property (p_sdoe) else $error("sync data enable");
    property p_cloe; up_r == 3'h4 |-> ctrl_line_oe_n ==
        !($past(device_select, 3) && $past(host_write_cycle, 3)); endproperty
    a_cloe: assert property (p_cloe) else $error("control line enable");
    property p_seloe; up_r == 3'h4 |-> select_oe_n == !$past(device_select, 3); endproperty
    a_seloe: assert property (p_seloe) else $error("select enable");
    property p_sled; $fell(sync_err_led) |-> $past(error_clear, 4); endproperty
    a_sled: assert property (p_sled) else $error("sync flag dropped");
    property p_cled; $fell(ctrl_err_led) |-> $past(error_clear, 4); endproperty
    a_cled: assert property (p_cled) else $error("control flag dropped");
    property p_irq; $rose(irq) |-> sync_err_led || ctrl_err_led; endproperty
    a_irq: assert property (p_irq) else $error("irq without event");
    property p_rdy; psel && !penable |=> pready && penable; endproperty
    a_rdy: assert property (p_rdy) else $error("access phase not one cycle");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
endmodule
`default_nettype wire

// File: verif/dbp_drive_model.sv
// drive side: answers register reads on the control lines
`timescale 1ns/100ps
`default_nettype none
module dbp_drive_model
    import dbp_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  remote_read_gate,
    input  wire logic [DBP_CTRL_W-1:0] reg_value,
    input  wire logic                  corrupt,
    output var  logic [DBP_CTRL_W-1:0] ctrl_line_in,
    output var  logic                  ctrl_parity_in
);
    logic hold_r; // keeps data one cycle past the gate's fall
    logic par;    // parity the drive sends

    always_ff @(posedge pclk) begin
        hold_r <= remote_read_gate;
    end

    // odd parity unless a scenario asks for a broken word
    assign par = ~^reg_value ^ corrupt;

    // released lines show the inverse so stale values never pass
    always_comb begin
        if (remote_read_gate || hold_r) begin
            ctrl_line_in   = reg_value;
            ctrl_parity_in = par;
        end else begin
            ctrl_line_in   = ~reg_value;
            ctrl_parity_in = ~par;
        end
    end
endmodule
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the drive-bus parity block
`timescale 1ns/100ps
`default_nettype none
module tb
    import dbp_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic        host_data_strobe, write_op, remote_read_gate, rerr;
    logic        attn_summary_select, error_clear, sync_data_gate;
    logic        device_select, host_write_cycle, buffer_parity_bit;
    logic        ctrl_parity_in, sync_data_oe_n, sync_parity_out;
    logic        sync_parity_oe_n, ctrl_line_oe_n, ctrl_parity_out;
    logic        select_oe_n, sync_err_led, ctrl_err_led, irq, corrupt;
    logic [17:0] output_buffer, sync_data_out;
    logic [15:0] ctrl_line_in, host_write_data, ctrl_line_out, reg_value;
    logic [4:0]  register_select_in, register_select;
    logic [2:0]  unit_select_in, unit_select;
    logic [17:0] wl [4] = '{18'h0, 18'h1, 18'h3ffff, 18'h2b6d5};
    int          n_mismatch, check_count, m, i;

    dbp_top i_dbp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .host_data_strobe, .write_op,
        .remote_read_gate, .attn_summary_select, .error_clear,
        .sync_data_gate, .device_select, .host_write_cycle, .output_buffer,
        .buffer_parity_bit, .ctrl_line_in, .ctrl_parity_in, .host_write_data,
        .register_select_in, .unit_select_in, .sync_data_out, .sync_data_oe_n,
        .sync_parity_out, .sync_parity_oe_n, .ctrl_line_out, .ctrl_line_oe_n,
        .ctrl_parity_out, .register_select, .unit_select, .select_oe_n,
        .sync_err_led, .ctrl_err_led, .irq);
    dbp_drive_model i_dbp_drive_model (.pclk, .remote_read_gate, .reg_value,
        .corrupt, .ctrl_line_in, .ctrl_parity_in);

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; only the watchdog bounds the wait for ready
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask

    // strobe or read gate: data set up 3 cycles, high 4, then settle
    task automatic pulse(input logic ctrl);
        tick(3);
        remote_read_gate <= ctrl;
        host_data_strobe <= !ctrl;
        tick(4);
        remote_read_gate <= 1'b0;
        host_data_strobe <= 1'b0;
        tick(8);
    endtask

    task automatic clr();
        error_clear <= 1'b1;
        tick(2);
        error_clear <= 1'b0;
        tick(6);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // watchdog: the sequence needs under a thousand cycles
    initial begin
        #(25 * 4000);
        n_mismatch++;
        close_out();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {host_data_strobe, write_op, remote_read_gate} = '0;
        {attn_summary_select, error_clear, sync_data_gate} = '0;
        {device_select, host_write_cycle, buffer_parity_bit} = '0;
        {output_buffer, host_write_data, register_select_in} = '0;
        {unit_select_in, reg_value, corrupt} = '0;
        tick(4);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(DBP_CS1_OFF, 32'h0);
        rchk(DBP_CS2_OFF, 32'h0);
        rchk(DBP_ISTAT_OFF, 32'h0);
        rchk(DBP_IEN_OFF, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({rdat[30:0], rerr}, 32'h1);
        $display("test reset done");
        write_op <= 1'b1;
        device_select <= 1'b1;
        host_write_cycle <= 1'b1;
        for (m = 0; m < 2; m++) begin
            apb(1'b1, DBP_CS2_OFF, 32'(m << DBP_CS2_PAT_BIT));
            for (i = 0; i < 4; i++) begin
                output_buffer <= wl[i];
                sync_data_gate <= (i < 3);
                host_write_data <= wl[i][15:0];
                register_select_in <= 5'(i);
                unit_select_in <= 3'(7 - i);
                tick(5);
                chk(32'(sync_parity_out), 32'((i == 3 ? 1'b1 : ~^wl[i]) ^ m[0]));
                chk(32'(sync_data_oe_n), 32'(i == 3));
                chk(32'(sync_data_out), 32'(wl[i]));
                chk(32'(ctrl_parity_out), 32'(~^wl[i][15:0] ^ m[0]));
                chk(32'(ctrl_line_out), 32'(wl[i][15:0]));
                chk(32'({unit_select, register_select}), 32'({3'(7 - i), 5'(i)}));
                chk(32'({sync_parity_oe_n, ctrl_line_oe_n, select_oe_n}), 32'h0);
            end
        end
        write_op <= 1'b0;
        device_select <= 1'b0;
        tick(5);
        chk(32'({sync_parity_oe_n, ctrl_line_oe_n, select_oe_n}), 32'h7);
        $display("test generate done");
        apb(1'b1, DBP_IEN_OFF, 32'h3);
        output_buffer <= 18'h3;
        pulse(1'b0);
        rchk(DBP_CS2_OFF, 32'h10);
        apb(1'b1, DBP_CS2_OFF, 32'h0);
        buffer_parity_bit <= 1'b1;
        pulse(1'b0);
        rchk(DBP_CS2_OFF, 32'h0);
        buffer_parity_bit <= 1'b0;
        pulse(1'b0);
        rchk(DBP_CS2_OFF, 32'h100);
        rchk(DBP_CS1_OFF, 32'h8000);
        chk(32'({sync_err_led, ctrl_err_led, irq}), 32'h5);
        apb(1'b1, DBP_IEN_OFF, 32'h0);
        tick(3);
        chk(32'(irq), 32'h0);
        clr();
        rchk(DBP_CS2_OFF, 32'h0);
        rchk(DBP_ISTAT_OFF, 32'h1);
        apb(1'b1, DBP_ICLR_OFF, 32'h3);
        rchk(DBP_ISTAT_OFF, 32'h0);
        $display("test sync check done");
        apb(1'b1, DBP_IEN_OFF, 32'h2);
        reg_value <= 16'h8001;
        corrupt <= 1'b1;
        attn_summary_select <= 1'b1;
        pulse(1'b1);
        rchk(DBP_CS1_OFF, 32'h0);
        attn_summary_select <= 1'b0;
        corrupt <= 1'b0;
        pulse(1'b1);
        rchk(DBP_CS1_OFF, 32'h0);
        corrupt <= 1'b1;
        pulse(1'b1);
        rchk(DBP_CS1_OFF, 32'ha000);
        chk(32'({sync_err_led, ctrl_err_led, irq}), 32'h3);
        rchk(DBP_ISTAT_OFF, 32'h2);
        clr();
        rchk(DBP_CS1_OFF, 32'h0);
        $display("test control check done");
        close_out();
    end
endmodule

bind dbp_top dbp_asserts i_dbp_asserts (.pclk, .presetn, .psel, .penable,
    .pready, .pslverr, .write_op, .sync_data_gate, .device_select,
    .host_write_cycle, .error_clear, .sync_data_oe_n, .sync_parity_oe_n,
    .ctrl_line_oe_n, .select_oe_n, .sync_err_led, .ctrl_err_led, .irq);
`default_nettype wire
